// ===== hw/gcpb_pkg.sv
// Purpose: constants and carriers for the gpio configuration port bank
// Assumes: byte-wide host i/o cycles, one per clock strobe
// Notes:   offsets are configuration register indices
package gcpb_pkg;
	localparam logic [7:0] UNLOCK_KEY      = 8'h87;
	localparam logic [7:0] EXIT_KEY        = 8'haa;
	localparam logic [7:0] IDX_DEV_SELECT  = 8'h07;
	localparam logic [7:0] LDEV_GPIO       = 8'h07;
	localparam logic [7:0] LDEV_ENABLE     = 8'h09;
	localparam logic [7:0] OFS_BANK_ENABLE = 8'h30;
	localparam logic [7:0] OFS_DIRECTION   = 8'he0;
	localparam logic [7:0] OFS_PIN_DATA    = 8'he1;
	localparam logic [7:0] OFS_POLARITY    = 8'he2;
	localparam int         ENABLE_BIT      = 7;
	localparam logic [7:0] RST_BANK_ENABLE = 8'h00;
	localparam logic [7:0] RST_DIRECTION   = 8'hff;
	localparam logic [7:0] RST_PIN_DATA    = 8'h00;
	localparam logic [7:0] RST_POLARITY    = 8'h00;
	localparam logic [7:0] RST_INDEX       = 8'h00;
	localparam logic [7:0] RST_LDEV        = 8'h00;

	typedef enum logic [2:0] {
		GCPB_LOCKED = 3'b001,
		GCPB_HALF   = 3'b010,
		GCPB_OPEN   = 3'b100
	} gcpb_mode_e;

	// one host i/o cycle: port select 0 = index, 1 = data
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       port;
		logic [7:0] wdata;
	} gcpb_req_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} gcpb_rsp_s;
endpackage

// ===== hw/gcpb_sync2.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: bits are independent levels
// Notes:   first stage read by second stage only
`timescale 1ns/1ps
`default_nettype none
module gcpb_sync2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	// levels
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gcpb_sync_s;

	gcpb_sync_s st_ff;
	gcpb_sync_s nxt_st;

	always_comb begin
		nxt_st.s1 = i_d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_q = st_ff.s2;
endmodule
`default_nettype wire

// ===== hw/gcpb_top.sv
// Purpose: eight-line gpio bank behind an indexed configuration port
// Assumes: i_req carries one host i/o cycle per strobe, same clock domain
// Notes:   read data answers one cycle after the read strobe
//
// Operation
// - two back-to-back unlock key writes to index port open config mode
// - exit key write to index port closes mode; data port writes ignored and data port reads float high after
// - device-select register picks bank; device 7 exposes gpio registers
// - device 9 offset 30h bit 7 enables the gpio bank
// - direction bit one makes line input, zero makes it driven output
// - data bit writable for outputs only; inputs read pin value
// - polarity bit one inverts between pin and data in both directions
`timescale 1ns/1ps
`default_nettype none
module gcpb_top
	import gcpb_pkg::*;
#(
	parameter int N_LINES = 8
) (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rstn,
	// host configuration port
	input  wire gcpb_req_s          i_req,
	output gcpb_rsp_s               o_rsp,
	output logic                    o_cfg_open,
	// gpio pins
	input  wire logic [N_LINES-1:0] i_pin,
	output logic      [N_LINES-1:0] o_pin,
	output logic      [N_LINES-1:0] o_pin_oe
);
	typedef struct packed {
		gcpb_mode_e         mode;
		logic [7:0]         index;
		logic [7:0]         ldev;
		logic [7:0]         bank_en;
		logic [N_LINES-1:0] dir;
		logic [N_LINES-1:0] data;
		logic [N_LINES-1:0] pol;
		gcpb_rsp_s          rsp;
		logic [N_LINES-1:0] pin_out;
		logic [N_LINES-1:0] pin_oe;
		logic               open;
	} gcpb_state_s;

	gcpb_state_s st_ff;
	gcpb_state_s nxt_st;
	logic [N_LINES-1:0] pin_sync;
	logic [N_LINES-1:0] pin_seen;
	logic [N_LINES-1:0] data_view;
	logic               gpio_sel;
	logic               en_sel;
	logic               idx_wr;
	logic               dat_wr;
	logic               dat_rd;

	gcpb_sync2 #(
		.W(N_LINES)
	) u_pin_sync (
		.i_clk (i_clk),
		.i_rstn(i_rstn),
		.i_d   (i_pin),
		.o_q   (pin_sync)
	);

	// inputs fold polarity inward; outputs show the stored bit
	assign pin_seen  = pin_sync ^ st_ff.pol;
	assign data_view = (st_ff.dir & pin_seen) | (~st_ff.dir & st_ff.data);
	assign gpio_sel  = (st_ff.ldev == LDEV_GPIO);
	assign en_sel    = (st_ff.ldev == LDEV_ENABLE);
	assign idx_wr    = i_req.wr && !i_req.port;
	assign dat_wr    = i_req.wr && i_req.port && st_ff.mode == GCPB_OPEN;
	assign dat_rd    = i_req.rd && i_req.port && st_ff.mode == GCPB_OPEN;

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.rsp.valid = 1'b0;
		// key sequence; any other index write between keys restarts it
		unique case (st_ff.mode)
			GCPB_LOCKED: begin
				if (idx_wr && i_req.wdata == UNLOCK_KEY) begin
					nxt_st.mode = GCPB_HALF;
				end
			end
			GCPB_HALF: begin
				if (idx_wr) begin
					nxt_st.mode = (i_req.wdata == UNLOCK_KEY) ?
						GCPB_OPEN : GCPB_LOCKED;
				end else if (i_req.wr || i_req.rd) begin
					nxt_st.mode = GCPB_LOCKED;
				end
			end
			GCPB_OPEN: begin
				if (idx_wr && i_req.wdata == EXIT_KEY) begin
					nxt_st.mode = GCPB_LOCKED;
				end else if (idx_wr) begin
					nxt_st.index = i_req.wdata;
				end
			end
			default: nxt_st.mode = GCPB_LOCKED;
		endcase

		if (dat_wr) begin
			if (st_ff.index == IDX_DEV_SELECT) begin
				nxt_st.ldev = i_req.wdata;
			end else if (en_sel && st_ff.index == OFS_BANK_ENABLE) begin
				nxt_st.bank_en = i_req.wdata;
			end else if (gpio_sel) begin
				unique case (st_ff.index)
					OFS_DIRECTION: nxt_st.dir = i_req.wdata[N_LINES-1:0];
					// input lines keep their stored bit
					OFS_PIN_DATA: nxt_st.data =
						(st_ff.dir & st_ff.data) |
						(~st_ff.dir & i_req.wdata[N_LINES-1:0]);
					OFS_POLARITY: nxt_st.pol = i_req.wdata[N_LINES-1:0];
					default: ;
				endcase
			end
		end

		if (i_req.rd && i_req.port) begin
			nxt_st.rsp.valid = 1'b1;
			nxt_st.rsp.rdata = 8'hff; // locked or unmapped reads float high
			if (dat_rd) begin
				if (st_ff.index == IDX_DEV_SELECT) begin
					nxt_st.rsp.rdata = st_ff.ldev;
				end else if (en_sel && st_ff.index == OFS_BANK_ENABLE) begin
					nxt_st.rsp.rdata = st_ff.bank_en;
				end else if (gpio_sel) begin
					unique case (st_ff.index)
						OFS_DIRECTION: nxt_st.rsp.rdata = 8'(st_ff.dir);
						OFS_PIN_DATA:  nxt_st.rsp.rdata = 8'(data_view);
						OFS_POLARITY:  nxt_st.rsp.rdata = 8'(st_ff.pol);
						default:       nxt_st.rsp.rdata = 8'hff;
					endcase
				end
			end
		end else if (i_req.rd) begin
			nxt_st.rsp.valid = 1'b1;
			nxt_st.rsp.rdata = st_ff.index;
		end

		// pins float while the bank is disabled
		nxt_st.pin_oe  = st_ff.bank_en[ENABLE_BIT] ? ~st_ff.dir : '0;
		nxt_st.pin_out = st_ff.data ^ st_ff.pol;
		nxt_st.open    = (nxt_st.mode == GCPB_OPEN);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff.mode    <= GCPB_LOCKED;
			st_ff.index   <= RST_INDEX;
			st_ff.ldev    <= RST_LDEV;
			st_ff.bank_en <= RST_BANK_ENABLE;
			st_ff.dir     <= N_LINES'(RST_DIRECTION);
			st_ff.data    <= N_LINES'(RST_PIN_DATA);
			st_ff.pol     <= N_LINES'(RST_POLARITY);
			st_ff.rsp     <= '0;
			st_ff.pin_out <= '0;
			st_ff.pin_oe  <= '0;
			st_ff.open    <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rsp      = st_ff.rsp;
	assign o_cfg_open = st_ff.open;
	assign o_pin      = st_ff.pin_out;
	assign o_pin_oe   = st_ff.pin_oe;

	a_unlock_two_keys: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(st_ff.mode == GCPB_LOCKED && idx_wr && i_req.wdata == UNLOCK_KEY)
		##1 (idx_wr && i_req.wdata == UNLOCK_KEY) |=> o_cfg_open)
		else $error("double unlock key did not open mode");
	a_restart_on_access: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(st_ff.mode == GCPB_HALF && (i_req.wr || i_req.rd)
		&& !(idx_wr && i_req.wdata == UNLOCK_KEY)) |=> !o_cfg_open)
		else $error("mode opened across an interrupting access");
	a_single_key_closed: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(st_ff.mode == GCPB_LOCKED) |=> !o_cfg_open)
		else $error("mode opened after a single key");
	a_exit_key_locks: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(o_cfg_open && idx_wr && i_req.wdata == EXIT_KEY) |=> !o_cfg_open)
		else $error("exit key did not close mode");
	a_locked_no_write: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(!o_cfg_open && i_req.wr && i_req.port) |=> $stable(st_ff.dir)
		&& $stable(st_ff.ldev) && $stable(st_ff.data))
		else $error("register changed while locked");
	a_locked_reads_float: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(!o_cfg_open && i_req.rd && i_req.port) |=> o_rsp.rdata == 8'hff)
		else $error("locked data read did not float high");
	a_ldev_select: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(dat_wr && st_ff.index == IDX_DEV_SELECT)
		|=> st_ff.ldev == $past(i_req.wdata))
		else $error("device select not stored");
	a_enable_gates_oe: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		!st_ff.bank_en[ENABLE_BIT] |=> o_pin_oe == '0)
		else $error("pins driven while bank disabled");
	a_dir_drives_oe: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		st_ff.bank_en[ENABLE_BIT] |=> o_pin_oe == ~$past(st_ff.dir))
		else $error("output enable does not follow direction");
	a_input_bit_held: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(dat_wr && gpio_sel && st_ff.index == OFS_PIN_DATA)
		|=> (st_ff.data & $past(st_ff.dir))
		== ($past(st_ff.data) & $past(st_ff.dir)))
		else $error("input line data bit was written");
	a_input_reads_pin: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(dat_rd && gpio_sel && st_ff.index == OFS_PIN_DATA)
		|=> (o_rsp.rdata[N_LINES-1:0] & $past(st_ff.dir))
		== (($past(pin_sync) ^ $past(st_ff.pol)) & $past(st_ff.dir)))
		else $error("input line read ignores pin or polarity");
	a_polarity_out: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		1'b1 |=> o_pin == ($past(st_ff.data) ^ $past(st_ff.pol)))
		else $error("driven level ignores polarity");
	a_read_answer_next: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		1'b1 |=> o_rsp.valid == $past(i_req.rd))
		else $error("read answer not one cycle after strobe");
	a_index_decode: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(dat_wr && gpio_sel && st_ff.index == OFS_POLARITY)
		|=> st_ff.pol == $past(i_req.wdata[N_LINES-1:0]))
		else $error("data port ignored last index");
endmodule
`default_nettype wire

// ===== tb/gcpb_top_tb.sv
// Purpose: self-checking bench for the gpio configuration port bank
// Assumes: one host i/o cycle per clock, inputs driven 1 ns after the edge
// Notes:   requests are held until the next call replaces them
`timescale 1ns/1ps
`default_nettype none
module gcpb_top_tb
	import gcpb_pkg::*;
;

	logic       i_clk;
	logic       i_rstn;
	gcpb_req_s  i_req;
	gcpb_rsp_s  o_rsp;
	logic       o_cfg_open;
	logic [7:0] i_pin;
	logic [7:0] o_pin;
	logic [7:0] o_pin_oe;
	int         n_mismatch;
	int         check_count;
	int         cycles;

	gcpb_top #(.N_LINES(8)) uut (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_req      (i_req),
		.o_rsp      (o_rsp),
		.o_cfg_open (o_cfg_open),
		.i_pin      (i_pin),
		.o_pin      (o_pin),
		.o_pin_oe   (o_pin_oe)
	);

	always #2.5 i_clk = ~i_clk;

	task automatic results();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// generous ceiling: the whole sequence needs well under 200 cycles
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one strobe cycle; caller is already 1 ns past an edge
	task automatic io(input logic w, input logic r, input logic p,
			input logic [7:0] d);
		i_req = '{wr: w, rd: r, port: p, wdata: d};
		@(posedge i_clk);
		#1;
	endtask

	task automatic idle(input int n);
		repeat (n) io(1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	// answer is due in the cycle right after the strobe edge
	task automatic rdat(input logic [7:0] exp);
		io(1'b0, 1'b1, 1'b1, 8'h00);
		chk({7'h00, o_rsp.valid}, 8'h01);
		chk(o_rsp.rdata, exp);
		idle(1);
		chk({7'h00, o_rsp.valid}, 8'h00);
	endtask

	task automatic setreg(input logic [7:0] idx, input logic [7:0] v);
		io(1'b1, 1'b0, 1'b0, idx);
		io(1'b1, 1'b0, 1'b1, v);
		idle(1);
	endtask

	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
		io(1'b1, 1'b0, 1'b0, idx);
		rdat(exp);
	endtask

	initial begin
		i_clk = 1'b0;
		i_rstn = 1'b0;
		i_req = '0;
		i_pin = 8'h05;
		n_mismatch = 0;
		check_count = 0;
		repeat (5) @(posedge i_clk);
		#1;
		i_rstn = 1'b1;
		chk({7'h00, o_cfg_open}, 8'h00);
		chk(o_pin_oe, 8'h00);
		rdat(8'hff);
		// an access between the two keys must restart the sequence
		io(1'b1, 1'b0, 1'b0, UNLOCK_KEY);
		io(1'b1, 1'b0, 1'b0, 8'h07);
		io(1'b1, 1'b0, 1'b0, UNLOCK_KEY);
		chk({7'h00, o_cfg_open}, 8'h00);
		io(1'b1, 1'b0, 1'b0, UNLOCK_KEY);
		chk({7'h00, o_cfg_open}, 8'h01);
		idle(1);
		setreg(IDX_DEV_SELECT, LDEV_ENABLE);
		setreg(OFS_BANK_ENABLE, 8'h80);
		rreg(OFS_BANK_ENABLE, 8'h80);
		rreg(IDX_DEV_SELECT, 8'h09);
		setreg(IDX_DEV_SELECT, LDEV_GPIO);
		rreg(OFS_BANK_ENABLE, 8'hff);
		setreg(OFS_DIRECTION, 8'h0f);
		setreg(OFS_POLARITY, 8'h33);
		setreg(OFS_PIN_DATA, 8'hff);
		idle(3);
		chk(o_pin_oe, 8'hf0);
		chk(o_pin & o_pin_oe, 8'hc0);
		rreg(OFS_DIRECTION, 8'h0f);
		rreg(OFS_POLARITY, 8'h33);
		// index port read returns the last stored index
		io(1'b0, 1'b1, 1'b0, 8'h00);
		chk(o_rsp.rdata, OFS_POLARITY);
		idle(1);
		// low nibble is input: pin ^ polarity, write of ones had no effect
		rreg(OFS_PIN_DATA, 8'hf6);
		i_pin = 8'h0a;
		idle(3);
		rreg(OFS_PIN_DATA, 8'hf9);
		setreg(IDX_DEV_SELECT, LDEV_ENABLE);
		setreg(OFS_BANK_ENABLE, 8'h00);
		idle(3);
		chk(o_pin_oe, 8'h00);
		io(1'b1, 1'b0, 1'b0, EXIT_KEY);
		chk({7'h00, o_cfg_open}, 8'h00);
		idle(1);
		// data writes while locked must not land
		setreg(IDX_DEV_SELECT, LDEV_GPIO);
		rreg(IDX_DEV_SELECT, 8'hff);
		io(1'b1, 1'b0, 1'b0, UNLOCK_KEY);
		io(1'b1, 1'b0, 1'b0, UNLOCK_KEY);
		rreg(IDX_DEV_SELECT, 8'h09);
		results();
	end
endmodule
`default_nettype wire
